//--- rtl/clf_fabric.sv
`timescale 1ns/1ps

// Overview of operation
// - Each cell has a 4-input lookup, one storage element, five inputs, three outputs.
// - Each cell passes its direct input straight through, leaving lookup and storage free.
// - Configuration selects edge flop or level latch for each storage element.
// - Cell control gives arithmetic carry or a cascade chain for wide decodes.
// - Block clear is active high, never inverted, and disableable per flop.
// - Chip-wide clear resets all storage at reset, reconfiguration, or net assertion.
// - Chip-wide clear comes from any pad, optionally inverted, or an internal node.
// - Output float input tristates pads without clearing any flop.
// - Flop and latch both have clock enable and clear.
// - Four long-line drivers, each set buffer or three-state by its own bit.
// - In three-state mode one block gate control enables all four drivers.
// - Gate control 1 floats the driver; 0 passes the input unchanged.
// - Each driver can drive two horizontal and two vertical long lines.
// - A keeper holds each undriven line's last level; any driver overrides it.
// - Pads are input, output or bidirectional; data, enable and input invertible.
// - Pads store nothing; registering is done in cell storage.
// - Each pad input has one delay tap, inserted by default.
module clf_fabric (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Logic cell fabric side
  input  wire logic [15:0] cell_func_in,
  input  wire logic [3:0]  cell_direct_in,
  input  wire logic [3:0]  cell_clk_en,
  input  wire logic        block_clear_input,
  input  wire logic        chain_in,
  output logic             chain_out,
  output logic      [3:0]  cell_func_out,
  output logic      [3:0]  cell_store_out,
  output logic      [3:0]  cell_thru_out,
  // Long lines
  input  wire logic        output_drive_gate,
  output logic      [3:0]  long_line,
  output logic      [3:0]  long_line_driven,
  // Pads
  input  wire logic        output_float,
  input  wire logic [3:0]  pad_i,
  output logic      [3:0]  pad_o,
  output logic      [3:0]  pad_oe,
  input  wire logic [3:0]  pad_core_dout,
  input  wire logic [3:0]  pad_core_tsc,
  output logic      [3:0]  pad_core_din
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]      ctrl;
    logic [3:0][31:0] cell_cfg;
    logic [31:0]      drv;
    logic [31:0]      pad;
    logic             reconf;
    logic             gclr;
    logic [3:0]       pin_s1;
    logic [3:0]       pin_s2;
    logic [3:0]       pin_dly;
    logic             flt_s1;
    logic             flt_s2;
    logic [3:0]       keep;
  } clf_fabric_state_type;

  clf_fabric_state_type st_r;
  clf_fabric_state_type st_nxt;

  // Bus decode
  logic             access;
  logic             wr_en;
  logic             cell_hit;
  logic [1:0]       cell_idx;
  logic             addr_hit;

  // Carry chain
  logic [4:0]       chain;

  // Long lines
  logic [3:0]       drv_on;
  logic [3:0][3:0]  drv_map;
  logic [3:0]       line_val;

  // Clear and status
  logic [1:0]       gclr_sel;
  logic             gclr_src;
  logic [31:0]      status;

  function automatic logic [31:0] clf_merge(
    input logic [31:0] old_v,
    input logic [31:0] wdata,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] v;
    v = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        v[8*b +: 8] = wdata[8*b +: 8];
    end
    return v & mask;
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign access   = psel & penable;
  assign wr_en    = access & pwrite;
  assign cell_hit = (paddr >= clf_pkg::ADDR_CELL_BASE) &&
                    (paddr <= clf_pkg::ADDR_CELL_LAST) && (paddr[1:0] == 2'h0);
  assign cell_idx = paddr[3:2];
  assign addr_hit = cell_hit ||
                    (paddr == clf_pkg::ADDR_CTRL) ||
                    (paddr == clf_pkg::ADDR_DRIVER) ||
                    (paddr == clf_pkg::ADDR_PAD) ||
                    (paddr == clf_pkg::ADDR_STATUS);

  assign pready   = 1'b1;
  assign pslverr  = access & ~addr_hit;

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (psel)
    begin
      if (cell_hit)
        prdata = st_r.cell_cfg[cell_idx];
      else if (paddr == clf_pkg::ADDR_CTRL)
        prdata = st_r.ctrl;
      else if (paddr == clf_pkg::ADDR_DRIVER)
        prdata = st_r.drv;
      else if (paddr == clf_pkg::ADDR_PAD)
        prdata = st_r.pad;
      else if (paddr == clf_pkg::ADDR_STATUS)
        prdata = status;
      else
        prdata = 32'h0000_0000;
    end
  end

  always_comb
  begin
    status = 32'h0000_0000;
    status[clf_pkg::ST_Q_LSB +: 4]    = cell_store_out;
    status[clf_pkg::ST_X_LSB +: 4]    = cell_func_out;
    status[clf_pkg::ST_LINE_LSB +: 4] = line_val;
    status[clf_pkg::ST_PAD_LSB +: 4]  = pad_core_din;
    status[clf_pkg::ST_GCLR]          = st_r.gclr;
  end

  // ----------------------------------------------------------------
  // Chip-wide clear source
  // ----------------------------------------------------------------
  assign gclr_sel = st_r.ctrl[clf_pkg::CTRL_SEL_LSB +: 2];

  assign gclr_src = st_r.ctrl[clf_pkg::CTRL_SRC_INT] ? cell_func_out[gclr_sel] :
                    (st_r.pin_s2[gclr_sel] ^ st_r.ctrl[clf_pkg::CTRL_INV]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt         = st_r;
    // Synchronisers
    st_nxt.pin_s1  = pad_i;
    st_nxt.pin_s2  = st_r.pin_s1;
    st_nxt.pin_dly = st_r.pin_s2;
    st_nxt.flt_s1  = output_float;
    st_nxt.flt_s2  = st_r.flt_s1;

    st_nxt.keep    = line_val;
    st_nxt.reconf  = 1'b0;

    st_nxt.gclr    = st_r.reconf | gclr_src;

    // Bus write
    if (wr_en)
    begin
      if (cell_hit)
        st_nxt.cell_cfg[cell_idx] = clf_merge(st_r.cell_cfg[cell_idx], pwdata, pstrb,
                                              clf_pkg::CELL_MASK);
      else if (paddr == clf_pkg::ADDR_CTRL)
      begin
        st_nxt.ctrl   = clf_merge(st_r.ctrl, pwdata, pstrb, clf_pkg::CTRL_MASK);
        st_nxt.reconf = pstrb[0] & pwdata[clf_pkg::CTRL_RECONF];
      end
      else if (paddr == clf_pkg::ADDR_DRIVER)
        st_nxt.drv = clf_merge(st_r.drv, pwdata, pstrb, clf_pkg::DRV_MASK);
      else if (paddr == clf_pkg::ADDR_PAD)
        st_nxt.pad = clf_merge(st_r.pad, pwdata, pstrb, clf_pkg::PAD_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r          <= '0;
      st_r.ctrl     <= clf_pkg::CTRL_RST;
      st_r.cell_cfg <= {clf_pkg::N_CELLS{clf_pkg::CELL_RST}};
      st_r.drv      <= clf_pkg::DRV_RST;
      st_r.pad      <= clf_pkg::PAD_RST;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Logic cells
  // ----------------------------------------------------------------
  assign chain[0]  = chain_in;
  assign chain_out = chain[clf_pkg::N_CELLS];

  for (genvar c = 0; c < clf_pkg::N_CELLS; c++)
  begin : g_cell
    clf_logic_cell u_cell (
      .pclk                (pclk),
      .presetn             (presetn),
      .cfg                 (st_r.cell_cfg[c]),
      .func_in             (cell_func_in[4*c +: 4]),
      .direct_in           (cell_direct_in[c]),
      .clk_en              (cell_clk_en[c]),
      .block_clear_input   (block_clear_input),
      .chip_wide_clear_net (st_r.gclr),
      .chain_in            (chain[c]),
      .chain_out           (chain[c+1]),
      .func_out            (cell_func_out[c]),
      .store_out           (cell_store_out[c]),
      .thru_out            (cell_thru_out[c])
    );
  end

  // ----------------------------------------------------------------
  // Long-line drivers and keepers
  // ----------------------------------------------------------------
  for (genvar d = 0; d < clf_pkg::N_DRIVERS; d++)
  begin : g_drv
    assign drv_on[d]  = ~st_r.drv[clf_pkg::DRV_TS_LSB + d] | ~output_drive_gate;
    assign drv_map[d] = st_r.drv[clf_pkg::DRV_MAP_LSB + 4*d +: 4];
  end

  for (genvar l = 0; l < clf_pkg::N_LINES; l++)
  begin : g_line
    logic [3:0] act;

    for (genvar d = 0; d < clf_pkg::N_DRIVERS; d++)
    begin : g_act
      assign act[d] = drv_on[d] & drv_map[d][l];
    end

    assign long_line_driven[l] = |act;
    assign line_val[l] = (|act) ? |(act & cell_func_out) : st_r.keep[l];
  end

  assign long_line = line_val;

  // ----------------------------------------------------------------
  // Pad interface cells
  // ----------------------------------------------------------------
  for (genvar p = 0; p < clf_pkg::N_PADS; p++)
  begin : g_pad
    clf_pad_cell u_pad (
      .cfg          (st_r.pad[clf_pkg::PAD_FIELD_W*p +: clf_pkg::PAD_FIELD_W]),
      .output_float (st_r.flt_s2),
      .core_dout    (pad_core_dout[p]),
      .core_tsc     (pad_core_tsc[p]),
      .core_din     (pad_core_din[p]),
      .pin_now      (st_r.pin_s2[p]),
      .pin_dly      (st_r.pin_dly[p]),
      .pad_o        (pad_o[p]),
      .pad_oe       (pad_oe[p])
    );
  end

endmodule

//--- pkg/clf_pkg.sv
package clf_pkg;

  // ----------------------------------------------------------------
  // Structure sizes
  // ----------------------------------------------------------------
  localparam int N_CELLS   = 4;
  localparam int N_DRIVERS = 4;
  localparam int N_LINES   = 4;
  localparam int N_PADS    = 4;
  localparam int LUT_W     = 16;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_CELL_BASE = 12'h010;
  localparam logic [11:0] ADDR_CELL_LAST = 12'h01c;
  localparam logic [11:0] ADDR_DRIVER    = 12'h020;
  localparam logic [11:0] ADDR_PAD       = 12'h024;
  localparam logic [11:0] ADDR_STATUS    = 12'h028;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int          CTRL_SRC_INT = 0;
  localparam int          CTRL_INV     = 1;
  localparam int          CTRL_SEL_LSB = 2;
  localparam int          CTRL_RECONF  = 4;
  localparam logic [31:0] CTRL_MASK    = 32'h0000_000f;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Logic cell configuration fields
  // ----------------------------------------------------------------
  localparam int          CF_LUT_LSB = 0;
  localparam int          CF_LATCH   = 16;
  localparam int          CF_CARRY   = 17;
  localparam int          CF_CASCADE = 18;
  localparam int          CF_CLR_DIS = 19;
  localparam int          CF_DSEL    = 20;
  localparam logic [31:0] CELL_MASK  = 32'h001f_ffff;
  localparam logic [31:0] CELL_RST   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Long-line driver fields
  // ----------------------------------------------------------------
  localparam int          DRV_TS_LSB  = 0;
  localparam int          DRV_MAP_LSB = 4;
  localparam logic [31:0] DRV_MASK    = 32'h000f_ffff;
  localparam logic [31:0] DRV_RST     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Pad interface cell fields (six bits per pad)
  // ----------------------------------------------------------------
  localparam int          PAD_FIELD_W = 6;
  localparam int          PF_MODE_LSB = 0;
  localparam int          PF_OUT_INV  = 2;
  localparam int          PF_OE_INV   = 3;
  localparam int          PF_IN_INV   = 4;
  localparam int          PF_DLY_BYP  = 5;
  localparam logic [31:0] PAD_MASK    = 32'h00ff_ffff;
  localparam logic [31:0] PAD_RST     = 32'h0000_0000;

  typedef enum logic [1:0] {
    CLF_PAD_IN,
    CLF_PAD_OUT,
    CLF_PAD_BIDIR,
    CLF_PAD_RSVD
  } clf_pad_mode_type;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int ST_Q_LSB    = 0;
  localparam int ST_X_LSB    = 4;
  localparam int ST_LINE_LSB = 8;
  localparam int ST_PAD_LSB  = 12;
  localparam int ST_GCLR     = 16;

endpackage

//--- rtl/clf_logic_cell.sv
`timescale 1ns/1ps

module clf_logic_cell (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Configuration
  input  wire logic [31:0] cfg,
  // Five independent inputs
  input  wire logic [3:0]  func_in,
  input  wire logic        direct_in,
  // Storage control
  input  wire logic        clk_en,
  input  wire logic        block_clear_input,
  input  wire logic        chip_wide_clear_net,
  // Carry and cascade chain
  input  wire logic        chain_in,
  output logic             chain_out,
  // Three outputs
  output logic             func_out,
  output logic             store_out,
  output logic             thru_out
);

  typedef struct packed {
    logic q;
  } clf_cell_state_type;

  clf_cell_state_type st_r;
  clf_cell_state_type st_nxt;
  logic [15:0]        lut;
  logic               lut_out;
  logic               store_d;
  logic               clr;

  assign lut     = cfg[clf_pkg::CF_LUT_LSB +: clf_pkg::LUT_W];
  assign lut_out = lut[func_in];
  assign thru_out = direct_in;

  always_comb
  begin
    if (cfg[clf_pkg::CF_CARRY])
    begin
      func_out  = func_in[0] ^ func_in[1] ^ chain_in;
      chain_out = (func_in[0] & func_in[1]) | (chain_in & (func_in[0] ^ func_in[1]));
    end
    else if (cfg[clf_pkg::CF_CASCADE])
    begin
      func_out  = lut_out & chain_in;
      chain_out = lut_out & chain_in;
    end
    else
    begin
      func_out  = lut_out;
      chain_out = 1'b0;
    end
  end

  assign store_d = cfg[clf_pkg::CF_DSEL] ? direct_in : func_out;
  assign clr = chip_wide_clear_net | (block_clear_input & ~cfg[clf_pkg::CF_CLR_DIS]);

  always_comb
  begin
    st_nxt = st_r;
    if (clr)
      st_nxt.q = 1'b0;
    else if (clk_en)
      st_nxt.q = store_d;
  end

  assign store_out = (cfg[clf_pkg::CF_LATCH] & clk_en & ~clr) ? store_d : st_r.q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule

//--- rtl/clf_pad_cell.sv
`timescale 1ns/1ps

module clf_pad_cell (
  // Configuration
  input  wire logic [5:0] cfg,
  input  wire logic       output_float,
  // Core side
  input  wire logic       core_dout,
  input  wire logic       core_tsc,
  output logic            core_din,
  // Pin side, already synchronised
  input  wire logic       pin_now,
  input  wire logic       pin_dly,
  output logic            pad_o,
  output logic            pad_oe
);

  logic pin_sel;
  logic oe_raw;

  assign pin_sel = cfg[clf_pkg::PF_DLY_BYP] ? pin_now : pin_dly;

  assign pad_o  = core_dout ^ cfg[clf_pkg::PF_OUT_INV];

  always_comb
  begin
    oe_raw   = 1'b0;
    core_din = 1'b0;
    case (clf_pkg::clf_pad_mode_type'(cfg[clf_pkg::PF_MODE_LSB +: 2]))
      clf_pkg::CLF_PAD_IN:
      begin
        core_din = pin_sel ^ cfg[clf_pkg::PF_IN_INV];
      end
      clf_pkg::CLF_PAD_OUT:
      begin
        oe_raw = 1'b1;
      end
      clf_pkg::CLF_PAD_BIDIR:
      begin
        oe_raw   = ~(core_tsc ^ cfg[clf_pkg::PF_OE_INV]);
        core_din = pin_sel ^ cfg[clf_pkg::PF_IN_INV];
      end
      default:
      begin
        oe_raw   = 1'b0;
        core_din = 1'b0;
      end
    endcase
  end

  assign pad_oe = oe_raw & ~output_float;

endmodule

//--- testbench/clf_fabric_checker.sv
`timescale 1ns/1ps

// ----------------------------------------------------------
// Port checks with a shadow of the bus configuration
// ----------------------------------------------------------
module clf_fabric_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  // Cells
  input wire logic [3:0]  cell_direct_in,
  input wire logic        block_clear_input,
  input wire logic [3:0]  cell_func_out,
  input wire logic [3:0]  cell_store_out,
  input wire logic [3:0]  cell_thru_out,
  // Lines and pads
  input wire logic        output_drive_gate,
  input wire logic [3:0]  long_line,
  input wire logic [3:0]  long_line_driven,
  input wire logic        output_float,
  input wire logic [3:0]  pad_i,
  input wire logic [3:0]  pad_o,
  input wire logic [3:0]  pad_oe,
  input wire logic [3:0]  pad_core_dout,
  input wire logic [3:0]  pad_core_din
);
  logic [31:0] drv_r;
  logic [31:0] pad_r;
  logic [3:0]  cdis_r;
  logic [1:0]  age_r;
  logic        wr;
  logic [3:0]  xdrv;
  logic [3:0]  xval;
  logic [3:0]  m_in;
  logic [3:0]  m_out;
  logic [3:0]  oinv;
  logic [3:0]  iinv;
  logic [3:0]  byp;

  function automatic logic [31:0] mrg(input logic [31:0] o);
    for (int i = 0; i < 4; i++)
      if (pstrb[i])
        o[8*i +: 8] = pwdata[8*i +: 8];
    return o;
  endfunction

  assign wr = psel && penable && pwrite && pready;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drv_r  <= 32'h0;
      pad_r  <= 32'h0;
      cdis_r <= 4'h0;
      age_r  <= 2'h0;
    end
    else
    begin
      if (wr && paddr == clf_pkg::ADDR_DRIVER)
        drv_r <= mrg(drv_r) & clf_pkg::DRV_MASK;
      if (wr && paddr == clf_pkg::ADDR_PAD)
        pad_r <= mrg(pad_r) & clf_pkg::PAD_MASK;
      if (wr && paddr[11:4] == 8'h01 && paddr[1:0] == 2'h0 && pstrb[2])
        cdis_r[paddr[3:2]] <= pwdata[clf_pkg::CF_CLR_DIS];
      if (wr && paddr == clf_pkg::ADDR_PAD)
        age_r <= 2'h0;
      else if (age_r != 2'h3)
        age_r <= age_r + 2'h1;
    end
  end

  always_comb
  begin
    xdrv = 4'h0;
    xval = 4'h0;
    for (int d = 0; d < 4; d++)
    begin
      if (!(drv_r[d] && output_drive_gate))
      begin
        xdrv = xdrv | drv_r[4+4*d +: 4];
        xval = xval | (cell_func_out[d] ? drv_r[4+4*d +: 4] : 4'h0);
      end
    end
    for (int p = 0; p < 4; p++)
    begin
      m_in[p]  = pad_r[6*p +: 2] == 2'h0;
      m_out[p] = pad_r[6*p +: 2] == 2'h1 || pad_r[6*p +: 2] == 2'h2;
      oinv[p]  = pad_r[6*p+2];
      iinv[p]  = pad_r[6*p+4];
      byp[p]   = pad_r[6*p+5];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  thru_path_a: assert property (cell_thru_out == cell_direct_in)
    else $error("feedthrough differs from direct input");
  float_pads_a: assert property (output_float [*2] |=> pad_oe == 4'h0)
    else $error("pads still driven while floated");
  keeper_hold_a: assert property (
    (long_line & ~long_line_driven) == ($past(long_line) & ~long_line_driven))
    else $error("undriven line lost its level");
  line_driven_a: assert property (long_line_driven == xdrv)
    else $error("driver activity wrong for gate and mode");
  line_value_a: assert property ((long_line & long_line_driven) == xval)
    else $error("driven line value wrong");
  pad_out_a: assert property (((pad_o ^ pad_core_dout ^ oinv) & m_out) == 4'h0)
    else $error("pad output data wrong");
  pad_delay_a: assert property (age_r == 2'h3 |-> ((pad_core_din ^ iinv
    ^ ((byp & $past(pad_i, 2)) | (~byp & $past(pad_i, 3)))) & m_in) == 4'h0)
    else $error("pad input latency wrong");
  block_clear_a: assert property (
    block_clear_input [*2] |-> (cell_store_out & ~cdis_r) == 4'h0)
    else $error("block clear did not clear storage");
endmodule

bind clf_fabric clf_fabric_checker chk_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .cell_direct_in(cell_direct_in), .block_clear_input(block_clear_input),
  .cell_func_out(cell_func_out), .cell_store_out(cell_store_out),
  .cell_thru_out(cell_thru_out), .output_drive_gate(output_drive_gate),
  .long_line(long_line), .long_line_driven(long_line_driven),
  .output_float(output_float), .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe),
  .pad_core_dout(pad_core_dout), .pad_core_din(pad_core_din)
);

//--- testbench/clf_fabric_bench.sv
`timescale 1ns/1ps

module clf_fabric_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, cell_direct_in, cell_clk_en, cell_func_out, cell_store_out;
  logic [15:0] cell_func_in;
  logic [3:0]  cell_thru_out, long_line, long_line_driven, pad_i, pad_o, pad_oe;
  logic [3:0]  pad_core_dout, pad_core_tsc, pad_core_din;
  logic        block_clear_input, chain_in, chain_out, output_drive_gate, output_float;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  clf_fabric dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cell_func_in(cell_func_in), .cell_direct_in(cell_direct_in),
    .cell_clk_en(cell_clk_en), .block_clear_input(block_clear_input),
    .chain_in(chain_in), .chain_out(chain_out), .cell_func_out(cell_func_out),
    .cell_store_out(cell_store_out), .cell_thru_out(cell_thru_out),
    .output_drive_gate(output_drive_gate), .long_line(long_line),
    .long_line_driven(long_line_driven), .output_float(output_float), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe(pad_oe), .pad_core_dout(pad_core_dout),
    .pad_core_tsc(pad_core_tsc), .pad_core_din(pad_core_din)
  );

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x, "register read");
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rd(clf_pkg::ADDR_CTRL, clf_pkg::CTRL_RST);
    rd(clf_pkg::ADDR_DRIVER, clf_pkg::DRV_RST);
    rd(clf_pkg::ADDR_PAD, clf_pkg::PAD_RST);
    wr(clf_pkg::ADDR_PAD, 32'hffff_ffff);
    rd(clf_pkg::ADDR_PAD, clf_pkg::PAD_MASK);
    wr(clf_pkg::ADDR_PAD, 32'h0);
    apb(1'b0, 12'h100, 32'h0, q, e);
    chk(e, 1'b1, "unmapped error");
    $display("test regs done");
  endtask

  task automatic t_cell;
    wr(clf_pkg::ADDR_CELL_BASE, 32'h0000_8000);
    wr(clf_pkg::ADDR_CELL_BASE + 12'h4, 32'h0011_0000);
    cell_func_in   <= 16'h000f;
    cell_direct_in <= 4'ha;
    tick(2);
    chk(cell_func_out[0], 1'b1, "lookup and");
    chk(cell_thru_out, 4'ha, "feedthrough");
    chk(cell_store_out[0], 1'b0, "disabled flop");
    cell_clk_en <= 4'h3;
    tick(2);
    chk(cell_store_out[1:0], 2'h3, "capture");
    cell_direct_in <= 4'h8;
    tick(1);
    chk(cell_store_out[1:0], 2'h1, "latch transparent");
    cell_clk_en    <= 4'h0;
    cell_direct_in <= 4'ha;
    cell_func_in   <= 16'h0;
    tick(2);
    chk(cell_store_out[1:0], 2'h1, "hold");
    $display("test cells done");
  endtask

  task automatic t_chain;
    for (int c = 0; c < 4; c++)
      wr(clf_pkg::ADDR_CELL_BASE + 12'(4 * c), 32'h0002_0000);
    cell_func_in <= 16'h3333;
    tick(1);
    chk({chain_out, cell_func_out}, 5'h1e, "carry ripple");
    for (int c = 0; c < 4; c++)
      wr(clf_pkg::ADDR_CELL_BASE + 12'(4 * c), 32'h0004_ffff);
    chain_in <= 1'b1;
    tick(1);
    chk({chain_out, cell_func_out}, 5'h1f, "cascade high");
    chain_in <= 1'b0;
    tick(1);
    chk({chain_out, cell_func_out}, 5'h00, "cascade low");
    $display("test chain done");
  endtask

  task automatic t_clear;
    wr(clf_pkg::ADDR_CELL_BASE, 32'h0010_ffff);
    wr(clf_pkg::ADDR_CELL_BASE + 12'h4, 32'h0018_0000);
    cell_direct_in <= 4'hf;
    cell_clk_en    <= 4'h3;
    tick(2);
    block_clear_input <= 1'b1;
    tick(2);
    chk(cell_store_out[1:0], 2'h2, "block clear");
    block_clear_input <= 1'b0;
    cell_clk_en       <= 4'h0;
    wr(clf_pkg::ADDR_CTRL, 32'h0000_0010);
    tick(2);
    chk(cell_store_out, 4'h0, "reconfiguration clear");
    cell_clk_en <= 4'h3;
    wr(clf_pkg::ADDR_CTRL, 32'h0000_0002);
    tick(6);
    chk(cell_store_out[1:0], 2'h0, "inverted pad clear");
    wr(clf_pkg::ADDR_CTRL, 32'h0000_0001);
    tick(2);
    chk(cell_store_out[1:0], 2'h0, "internal clear");
    wr(clf_pkg::ADDR_CTRL, 32'h0);
    tick(6);
    chk(cell_store_out[1:0], 2'h3, "clear released");
    $display("test clear done");
  endtask

  task automatic t_lines;
    wr(clf_pkg::ADDR_CELL_BASE, 32'h0000_aaaa);
    wr(clf_pkg::ADDR_CELL_BASE + 12'h4, 32'h0000_aaaa);
    wr(clf_pkg::ADDR_DRIVER, 32'h0000_0251);
    cell_func_in <= 16'h0011;
    tick(1);
    chk({long_line_driven, long_line}, 8'h77, "lines driven");
    output_drive_gate <= 1'b1;
    cell_func_in      <= 16'h0010;
    tick(1);
    chk({long_line_driven, long_line}, 8'h27, "gate floats");
    output_drive_gate <= 1'b0;
    tick(1);
    chk({long_line_driven, long_line}, 8'h72, "gate drives");
    $display("test lines done");
  endtask

  task automatic t_pads;
    cell_func_in <= 16'h0011;
    cell_clk_en  <= 4'h3;
    tick(2);
    cell_clk_en <= 4'h0;
    wr(clf_pkg::ADDR_PAD, 32'h0008_5800);
    chk({pad_oe[3:2], pad_o[2]}, 3'h7, "output and bidir");
    pad_core_tsc <= 4'h8;
    tick(1);
    chk(pad_oe[3], 1'b0, "bidir released");
    output_float <= 1'b1;
    tick(3);
    chk(pad_oe, 4'h0, "float");
    chk(cell_store_out[1:0], 2'h3, "float keeps flops");
    output_float <= 1'b0;
    pad_i        <= 4'h3;
    tick(3);
    chk(pad_core_din[1:0], 2'h2, "bypass path");
    tick(1);
    chk(pad_core_din[1:0], 2'h3, "delayed path");
    pad_i <= 4'h0;
    $display("test pads done");
  endtask

  // ----------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, block_clear_input, chain_in} = '0;
    {output_drive_gate, output_float, paddr, pwdata} = '0;
    {cell_func_in, cell_direct_in, cell_clk_en, pad_i, pad_core_dout, pad_core_tsc} = '0;
    pstrb = 4'hf;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_cell();
    t_chain();
    t_clear();
    t_lines();
    t_pads();
    give_verdict();
  end
endmodule
